// ==== ext_irq_pkg.sv ====
// Constants shared by the extended interrupt mask and priority block
package ext_irq_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] ENABLE_A_IDX = 8'he6;
  localparam logic [7:0] ENABLE_B_IDX = 8'he7;
  localparam logic [7:0] PRIO_A_IDX = 8'hf6;
  localparam logic [7:0] RAW_STAT_IDX = 8'he8;
  localparam logic [7:0] REQ_STAT_IDX = 8'he9;
  localparam int ADDR_SHIFT = 2;
  localparam int IDX_W = 8;

  // Register layout
  localparam int REG_W = 8;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] ENABLE_A_WMASK = 8'hfd;
  localparam logic [7:0] ENABLE_B_WMASK = 8'h3f;
  localparam logic [7:0] PRIO_A_WMASK = 8'hfd;

  // Source numbering in the request vector
  localparam int NUM_SRC = 12;
  localparam int SRC_SMBUS_A = 0;
  localparam int SRC_WINDOW = 2;
  localparam int SRC_CONV = 3;
  localparam int SRC_PCA = 4;
  localparam int SRC_CMP_A = 5;
  localparam int SRC_CMP_B = 6;
  localparam int SRC_TIMER3 = 7;
  localparam int SRC_EXT = 8;
  localparam int SRC_UART_B = 9;
  localparam int SRC_SMBUS_B = 10;
  localparam int SRC_TIMER4 = 11;
  localparam int SRC_TIMER5 = 1;

  // Bit positions inside the second enable register
  localparam int EB_EXT = 0;
  localparam int EB_UART_B = 1;
  localparam int EB_SMBUS_B = 3;
  localparam int EB_TIMER4 = 4;
  localparam int EB_TIMER5 = 5;

  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

endpackage : ext_irq_pkg

// ==== ext_irq_mask_prio.sv ====
// Extended interrupt mask and priority logic with an AHB-Lite register port
// Function
// - Enable A bit 7 gates timer three
// - Enable A bit 6 gates comparator B
// - Enable A bit 5 gates comparator A
// - Enable A bit 4 gates counter array
// - Enable A bit 3 gates conversion done
// - Enable A bit 2 gates window compare
// - Bit 1 reserved, reads zero, write zero
// - Enable A bit 0 gates SMBus A
// - Priority bits 7..5 rank timer, comparators
// - Priority bits 4,3,2,0 rank counter array, conversion done, window compare, SMBus A
// - Enable B bits 7:6 read zero, ignored
// - Enable B bit 5 gates timer five
// - Enable B bit 4 gates timer four
// - Enable B bit 3 gates SMBus B
// - Enable B bit 1 gates UART B
// - Enable B bit 0 gates external level
// - Registers at E6, E7, F6 always
`timescale 1ns/100ps
module ext_irq_mask_prio
  import ext_irq_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic TIMER_THREE_LOW_OVF_IN,
  input wire logic TIMER_THREE_HIGH_OVF_IN,
  input wire logic TIMER_FOUR_LOW_OVF_IN,
  input wire logic TIMER_FOUR_HIGH_OVF_IN,
  input wire logic TIMER_FIVE_LOW_OVF_IN,
  input wire logic TIMER_FIVE_HIGH_OVF_IN,
  input wire logic COMPARATOR_A_RISE_FLAG_IN,
  input wire logic COMPARATOR_A_FALL_FLAG_IN,
  input wire logic COMPARATOR_B_RISE_FLAG_IN,
  input wire logic COMPARATOR_B_FALL_FLAG_IN,
  input wire logic COUNTER_ARRAY_IRQ_IN,
  input wire logic CONV_DONE_FLAG_IN,
  input wire logic WINDOW_CMP_FLAG_IN,
  input wire logic SMBUS_A_IRQ_IN,
  input wire logic SMBUS_B_IRQ_IN,
  input wire logic UART_B_IRQ_IN,
  input wire logic EXT_LEVEL_INPUT_IN,
  output logic [NUM_SRC-1:0] IRQ_REQ_OUT,
  output logic [NUM_SRC-1:0] IRQ_HIGH_OUT,
  output logic IRQ_ANY_HIGH_OUT,
  output logic IRQ_ANY_LOW_OUT
);

  logic [REG_W-1:0] enable_a_ff;
  logic [REG_W-1:0] enable_b_ff;
  logic [REG_W-1:0] prio_a_ff;
  logic [REG_W-1:0] nxt_enable_a;
  logic [REG_W-1:0] nxt_enable_b;
  logic [REG_W-1:0] nxt_prio_a;
  logic wr_pend_ff;
  logic [IDX_W-1:0] wr_idx_ff;
  logic [31:0] rdata_ff;
  logic ext_meta_ff;
  logic ext_sync_ff;
  logic [NUM_SRC-1:0] src_w;
  logic [NUM_SRC-1:0] en_w;
  logic [NUM_SRC-1:0] prio_w;
  logic [NUM_SRC-1:0] req_ff;
  logic [NUM_SRC-1:0] high_ff;
  logic any_high_ff;
  logic any_low_ff;
  logic addr_phase_w;
  logic [IDX_W-1:0] addr_idx_w;
  wire logic [NUM_SRC-1:0] gated_w;
  wire logic [NUM_SRC-1:0] ranked_w;

  // Word index out of a byte address; bits above the index are ignored
  function automatic logic [IDX_W-1:0] word_idx(input logic [31:0] addr);
    word_idx = addr[IDX_W+ADDR_SHIFT-1:ADDR_SHIFT];
  endfunction : word_idx

  // Read view of a register index; unmapped indices read zero
  function automatic logic [REG_W-1:0] read_view(
    input logic [IDX_W-1:0] idx,
    input logic [REG_W-1:0] ea,
    input logic [REG_W-1:0] eb,
    input logic [REG_W-1:0] pa,
    input logic [15:0] raw,
    input logic [15:0] req
  );
    case (idx)
      ENABLE_A_IDX: read_view = ea;
      ENABLE_B_IDX: read_view = eb;
      PRIO_A_IDX: read_view = pa;
      RAW_STAT_IDX: read_view = raw[REG_W-1:0];
      REQ_STAT_IDX: read_view = req[REG_W-1:0];
      default: read_view = REG_RESET;
    endcase
  endfunction : read_view

  // Valid transfer offered to this slave in the address phase
  assign addr_phase_w = HSEL_IN && HREADY_IN && (HTRANS_IN == HTRANS_NONSEQ);
  assign addr_idx_w = word_idx(HADDR_IN);

  // Address phase capture for the write that follows
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= '0;
    end else if (HREADY_IN) begin
      wr_pend_ff <= addr_phase_w && HWRITE_IN;
      wr_idx_ff <= addr_idx_w;
    end
  end

  // Next register values; reserved bit 1 and enable B bits 7:6 are masked off, unused enable B bit 2 is kept
  always_comb begin
    nxt_enable_a = enable_a_ff;
    nxt_enable_b = enable_b_ff;
    nxt_prio_a = prio_a_ff;
    if (wr_pend_ff) begin
      case (wr_idx_ff)
        ENABLE_A_IDX: nxt_enable_a = HWDATA_IN[REG_W-1:0] & ENABLE_A_WMASK;
        ENABLE_B_IDX: nxt_enable_b = HWDATA_IN[REG_W-1:0] & ENABLE_B_WMASK;
        PRIO_A_IDX: nxt_prio_a = HWDATA_IN[REG_W-1:0] & PRIO_A_WMASK;
        default: nxt_enable_a = enable_a_ff;
      endcase
    end
  end

  // Register storage; no page select exists, so every access hits them
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      enable_a_ff <= REG_RESET;
      enable_b_ff <= REG_RESET;
      prio_a_ff <= REG_RESET;
    end else begin
      enable_a_ff <= nxt_enable_a;
      enable_b_ff <= nxt_enable_b;
      prio_a_ff <= nxt_prio_a;
    end
  end

  // Read data registered at the address phase, forwarding a write in flight
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rdata_ff <= '0;
    end else if (addr_phase_w && !HWRITE_IN) begin
      rdata_ff <= {24'h000000, read_view(addr_idx_w, nxt_enable_a, nxt_enable_b,
        nxt_prio_a, {4'h0, src_w}, {4'h0, req_ff})};
    end
  end

  // Zero wait states and OKAY only, so both are constant flops
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= HRESP_OKAY;
    end else begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= HRESP_OKAY;
    end
  end
  assign HRDATA_OUT = rdata_ff;

  // External level input comes from a pin, so it is synchronised first
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
    end else begin
      ext_meta_ff <= EXT_LEVEL_INPUT_IN;
      ext_sync_ff <= ext_meta_ff;
    end
  end

  // Source requests; flags stay owned and cleared by their peripherals
  always_comb begin
    src_w = '0;
    src_w[SRC_TIMER3] = TIMER_THREE_LOW_OVF_IN | TIMER_THREE_HIGH_OVF_IN;
    src_w[SRC_CMP_B] = COMPARATOR_B_RISE_FLAG_IN | COMPARATOR_B_FALL_FLAG_IN;
    src_w[SRC_CMP_A] = COMPARATOR_A_RISE_FLAG_IN | COMPARATOR_A_FALL_FLAG_IN;
    src_w[SRC_PCA] = COUNTER_ARRAY_IRQ_IN;
    src_w[SRC_CONV] = CONV_DONE_FLAG_IN;
    src_w[SRC_WINDOW] = WINDOW_CMP_FLAG_IN;
    src_w[SRC_SMBUS_A] = SMBUS_A_IRQ_IN;
    src_w[SRC_TIMER5] = TIMER_FIVE_LOW_OVF_IN | TIMER_FIVE_HIGH_OVF_IN;
    src_w[SRC_TIMER4] = TIMER_FOUR_LOW_OVF_IN | TIMER_FOUR_HIGH_OVF_IN;
    src_w[SRC_SMBUS_B] = SMBUS_B_IRQ_IN;
    src_w[SRC_UART_B] = UART_B_IRQ_IN;
    src_w[SRC_EXT] = ext_sync_ff;
  end

  // Enable and priority per source; enable A bits line up with sources
  always_comb begin
    en_w = '0;
    prio_w = '0;
    en_w[SRC_TIMER3:SRC_SMBUS_A] = enable_a_ff;
    en_w[SRC_TIMER5] = enable_b_ff[EB_TIMER5];
    en_w[SRC_TIMER4] = enable_b_ff[EB_TIMER4];
    en_w[SRC_SMBUS_B] = enable_b_ff[EB_SMBUS_B];
    en_w[SRC_UART_B] = enable_b_ff[EB_UART_B];
    en_w[SRC_EXT] = enable_b_ff[EB_EXT];
    // Sources without a priority bit here always rank low
    prio_w[SRC_TIMER3:SRC_SMBUS_A] = prio_a_ff;
  end

  // Gating terms per source; nets, so each pass drives its own bit only
  generate
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      assign gated_w[i] = src_w[i] & en_w[i];
      assign ranked_w[i] = src_w[i] & en_w[i] & prio_w[i];
    end
  endgenerate

  // Gated request and rank flops; one process keeps a single driver per vector
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      req_ff <= '0;
      high_ff <= '0;
    end else begin
      req_ff <= gated_w;
      high_ff <= ranked_w;
    end
  end

  // Summary lines for the sequencer's two priority levels
  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      any_high_ff <= 1'b0;
      any_low_ff <= 1'b0;
    end else begin
      any_high_ff <= |(src_w & en_w & prio_w);
      any_low_ff <= |(src_w & en_w & ~prio_w);
    end
  end

  assign IRQ_REQ_OUT = req_ff;
  assign IRQ_HIGH_OUT = high_ff;
  assign IRQ_ANY_HIGH_OUT = any_high_ff;
  assign IRQ_ANY_LOW_OUT = any_low_ff;

  // Checks on the gating and register behaviour
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  timer3_gate_a: assert property (
    IRQ_REQ_OUT[SRC_TIMER3] == $past(enable_a_ff[7] &
      (TIMER_THREE_LOW_OVF_IN | TIMER_THREE_HIGH_OVF_IN)))
    else $error("timer three request not gated by enable bit");
  cmp_b_gate_a: assert property (
    IRQ_REQ_OUT[SRC_CMP_B] == $past(enable_a_ff[6] &
      (COMPARATOR_B_RISE_FLAG_IN | COMPARATOR_B_FALL_FLAG_IN)))
    else $error("comparator B request mismatch");
  cmp_a_gate_a: assert property (
    !enable_a_ff[5] |=> !IRQ_REQ_OUT[SRC_CMP_A])
    else $error("comparator A request passed while masked");
  pca_gate_a: assert property (
    (enable_a_ff[4] && COUNTER_ARRAY_IRQ_IN) |=> IRQ_REQ_OUT[SRC_PCA])
    else $error("counter array request lost");
  conv_gate_a: assert property (
    IRQ_REQ_OUT[SRC_CONV] == $past(enable_a_ff[3] & CONV_DONE_FLAG_IN))
    else $error("conversion done request mismatch");
  window_gate_a: assert property (
    IRQ_REQ_OUT[SRC_WINDOW] == $past(enable_a_ff[2] & WINDOW_CMP_FLAG_IN))
    else $error("window compare request mismatch");
  reserved_zero_a: assert property (
    !enable_a_ff[1] && !prio_a_ff[1] && enable_b_ff[7:6] == 2'h0)
    else $error("reserved or unused bit is set");
  smbus_a_gate_a: assert property (
    IRQ_REQ_OUT[SRC_SMBUS_A] == $past(enable_a_ff[0] & SMBUS_A_IRQ_IN))
    else $error("SMBus A request mismatch");
  high_rank_a: assert property (
    IRQ_HIGH_OUT == $past(src_w & en_w & prio_w))
    else $error("high priority vector mismatch");
  low_level_a: assert property (
    (IRQ_REQ_OUT != 12'h000 && IRQ_HIGH_OUT != IRQ_REQ_OUT) |-> IRQ_ANY_LOW_OUT)
    else $error("low priority summary missing");
  ext_sync_a: assert property (
    (enable_b_ff[EB_EXT] && EXT_LEVEL_INPUT_IN)[*3] |=> IRQ_REQ_OUT[SRC_EXT])
    else $error("external level request not passed after sync");
  enable_b_gate_a: assert property (
    (!enable_b_ff[EB_TIMER5] && !enable_b_ff[EB_TIMER4]) |=>
      !IRQ_REQ_OUT[SRC_TIMER5] && !IRQ_REQ_OUT[SRC_TIMER4])
    else $error("timer four or five passed while masked");
  uart_smb_b_a: assert property (
    IRQ_REQ_OUT[SRC_UART_B] == $past(enable_b_ff[EB_UART_B] & UART_B_IRQ_IN) &&
      IRQ_REQ_OUT[SRC_SMBUS_B] == $past(enable_b_ff[EB_SMBUS_B] & SMBUS_B_IRQ_IN))
    else $error("UART B or SMBus B request mismatch");
  write_lands_a: assert property (
    (addr_phase_w && HWRITE_IN && addr_idx_w == ENABLE_A_IDX) ##1 HREADY_IN
      |=> enable_a_ff == ($past(HWDATA_IN[REG_W-1:0]) & ENABLE_A_WMASK))
    else $error("enable A write did not land");
  read_back_a: assert property (
    (addr_phase_w && !HWRITE_IN && addr_idx_w == ENABLE_B_IDX)
      |=> HRDATA_OUT[7:6] == 2'h0 && HRDATA_OUT[31:8] == 24'h000000)
    else $error("unused enable B bits read nonzero");
  reset_zero_a: assert property (
    $rose(RESET_N_IN) |-> enable_a_ff == REG_RESET && prio_a_ff == REG_RESET)
    else $error("registers not zero after reset");
  hold_flag_a: assert property (
    (!enable_a_ff[4] && COUNTER_ARRAY_IRQ_IN) ##1 (enable_a_ff[4] && COUNTER_ARRAY_IRQ_IN)
      |=> IRQ_REQ_OUT[SRC_PCA])
    else $error("request not presented after re-enable");

  // Remaining gates, priority summaries and the register port
  timer4_gate_a: assert property (
    IRQ_REQ_OUT[SRC_TIMER4] == $past(enable_b_ff[EB_TIMER4] &
      (TIMER_FOUR_LOW_OVF_IN | TIMER_FOUR_HIGH_OVF_IN)))
    else $error("timer four request mismatch");
  timer5_gate_a: assert property (
    IRQ_REQ_OUT[SRC_TIMER5] == $past(enable_b_ff[EB_TIMER5] &
      (TIMER_FIVE_LOW_OVF_IN | TIMER_FIVE_HIGH_OVF_IN)))
    else $error("timer five request mismatch");
  ext_mask_a: assert property (
    !enable_b_ff[EB_EXT] |=> !IRQ_REQ_OUT[SRC_EXT])
    else $error("external level request passed while masked");
  cmp_a_pass_a: assert property (
    IRQ_REQ_OUT[SRC_CMP_A] == $past(enable_a_ff[5] &
      (COMPARATOR_A_RISE_FLAG_IN | COMPARATOR_A_FALL_FLAG_IN)))
    else $error("comparator A request mismatch");
  pca_mask_a: assert property (
    IRQ_REQ_OUT[SRC_PCA] == $past(enable_a_ff[4] & COUNTER_ARRAY_IRQ_IN))
    else $error("counter array request mismatch");
  high_subset_a: assert property (
    (IRQ_HIGH_OUT & ~IRQ_REQ_OUT) == 12'h000)
    else $error("high priority line without a request");
  any_high_a: assert property (
    IRQ_ANY_HIGH_OUT == (IRQ_HIGH_OUT != 12'h000))
    else $error("high priority summary mismatch");
  any_low_a: assert property (
    IRQ_ANY_LOW_OUT == ((IRQ_REQ_OUT & ~IRQ_HIGH_OUT) != 12'h000))
    else $error("low priority summary mismatch");
  fixed_low_a: assert property (
    !IRQ_HIGH_OUT[SRC_TIMER4] && !IRQ_HIGH_OUT[SRC_TIMER5] && !IRQ_HIGH_OUT[SRC_SMBUS_B]
      && !IRQ_HIGH_OUT[SRC_UART_B] && !IRQ_HIGH_OUT[SRC_EXT])
    else $error("source without priority bit ranked high");
  prio_write_a: assert property (
    (addr_phase_w && HWRITE_IN && addr_idx_w == PRIO_A_IDX) ##1 HREADY_IN
      |=> prio_a_ff == ($past(HWDATA_IN[REG_W-1:0]) & PRIO_A_WMASK))
    else $error("priority write did not land");
  enb_write_a: assert property (
    (addr_phase_w && HWRITE_IN && addr_idx_w == ENABLE_B_IDX) ##1 HREADY_IN
      |=> enable_b_ff == ($past(HWDATA_IN[REG_W-1:0]) & ENABLE_B_WMASK))
    else $error("enable B write did not land");
  reset_b_zero_a: assert property (
    $rose(RESET_N_IN) |-> enable_b_ff == REG_RESET && IRQ_REQ_OUT == 12'h000)
    else $error("enable B or requests not zero after reset");
  read_ea_a: assert property (
    (addr_phase_w && !HWRITE_IN && addr_idx_w == ENABLE_A_IDX && !wr_pend_ff)
      |=> HRDATA_OUT == {24'h000000, enable_a_ff})
    else $error("enable A read data mismatch");
  unmapped_zero_a: assert property (
    (addr_phase_w && !HWRITE_IN && addr_idx_w != ENABLE_A_IDX && addr_idx_w != ENABLE_B_IDX
      && addr_idx_w != PRIO_A_IDX && addr_idx_w != RAW_STAT_IDX
      && addr_idx_w != REQ_STAT_IDX) |=> HRDATA_OUT == 32'h00000000)
    else $error("unmapped index read nonzero");
  req_status_a: assert property (
    (addr_phase_w && !HWRITE_IN && addr_idx_w == REQ_STAT_IDX)
      |=> HRDATA_OUT[REG_W-1:0] == $past(IRQ_REQ_OUT[REG_W-1:0]))
    else $error("request status read mismatch");

  // Main scenarios
  high_irq_c: cover property (IRQ_ANY_HIGH_OUT && IRQ_ANY_LOW_OUT);
  mask_toggle_c: cover property (IRQ_REQ_OUT[SRC_TIMER3] ##1 !IRQ_REQ_OUT[SRC_TIMER3]);
  ext_req_c: cover property (IRQ_REQ_OUT[SRC_EXT]);
  rd_after_wr_c: cover property (wr_pend_ff && addr_phase_w && !HWRITE_IN);
  flag_reenable_c: cover property ($rose(enable_a_ff[4]) && COUNTER_ARRAY_IRQ_IN);

endmodule : ext_irq_mask_prio

// ==== ext_irq_src_model.sv ====
// Behavioural model of the peripheral flag sources facing the mask block
`timescale 1ns/100ps
module ext_irq_src_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [16:0] set_in,
  input wire logic [16:0] clr_in,
  output logic [16:0] flags_out
);
  logic [16:0] pend_ff;

  // Pending flags stay until the source clears them, never by masking
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_ff <= 17'h00000;
    end else begin
      pend_ff <= (pend_ff & ~clr_in) | set_in;
    end
  end

  assign flags_out = pend_ff;
endmodule : ext_irq_src_model

// ==== test_ext_irq_mask_prio.sv ====
// Self-checking testbench for the extended interrupt mask and priority block
`timescale 1ns/100ps
module test_ext_irq_mask_prio;
  import ext_irq_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [16:0] set_v = 17'h0;
  logic [16:0] clr_v = 17'h0;
  logic [16:0] f;
  logic [11:0] req;
  logic [11:0] high;
  logic any_h;
  logic any_l;
  int n_errors = 0;
  int cmp_count = 0;
  integer seed = 32'h028c0b3b;

  // 10 MHz clock
  always #50 clk = ~clk;

  ext_irq_src_model ext_irq_src_model_inst (.clk_in(clk), .rst_n_in(rst_n), .set_in(set_v),
    .clr_in(clr_v), .flags_out(f));

  ext_irq_mask_prio ext_irq_mask_prio_inst (.REF_CLK_IN(clk), .RESET_N_IN(rst_n),
    .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .TIMER_THREE_LOW_OVF_IN(f[0]), .TIMER_THREE_HIGH_OVF_IN(f[1]),
    .TIMER_FOUR_LOW_OVF_IN(f[2]), .TIMER_FOUR_HIGH_OVF_IN(f[3]),
    .TIMER_FIVE_LOW_OVF_IN(f[4]), .TIMER_FIVE_HIGH_OVF_IN(f[5]),
    .COMPARATOR_A_RISE_FLAG_IN(f[6]), .COMPARATOR_A_FALL_FLAG_IN(f[7]),
    .COMPARATOR_B_RISE_FLAG_IN(f[8]), .COMPARATOR_B_FALL_FLAG_IN(f[9]),
    .COUNTER_ARRAY_IRQ_IN(f[10]), .CONV_DONE_FLAG_IN(f[11]), .WINDOW_CMP_FLAG_IN(f[12]),
    .SMBUS_A_IRQ_IN(f[13]), .SMBUS_B_IRQ_IN(f[14]), .UART_B_IRQ_IN(f[15]),
    .EXT_LEVEL_INPUT_IN(f[16]), .IRQ_REQ_OUT(req), .IRQ_HIGH_OUT(high),
    .IRQ_ANY_HIGH_OUT(any_h), .IRQ_ANY_LOW_OUT(any_l));

  task end_sim;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Bounded wait for hready at a rising edge; a hang ends the run
  task wait_rdy;
    int i;
    i = 0;
    @(posedge clk);
    while (hready !== 1'b1 && i < 20) begin
      @(posedge clk);
      i++;
    end
    if (i >= 20) begin
      n_errors++;
      end_sim();
    end
  endtask : wait_rdy

  // One single AHB-Lite word transfer; read data taken at the data-phase edge
  task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
           output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  // Expected gated request vector in design bit order
  function automatic logic [11:0] exp_req(logic [16:0] v, logic [7:0] a, logic [7:0] b);
    return {(v[2] | v[3]) & b[4], v[14] & b[3], v[15] & b[1], v[16] & b[0],
            (v[0] | v[1]) & a[7], (v[8] | v[9]) & a[6], (v[6] | v[7]) & a[5],
            v[10] & a[4], v[11] & a[3], v[12] & a[2], (v[4] | v[5]) & b[5], v[13] & a[0]};
  endfunction : exp_req

  logic [31:0] rd;
  logic [7:0] ea;
  logic [7:0] eb;
  logic [7:0] pa;
  logic [16:0] v;
  logic [11:0] er;
  logic [11:0] eh;
  logic [11:0] raw_e;

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // Registers come up cleared, unmapped index reads zero
    bus(1'b0, ENABLE_A_IDX, 32'h0, rd); chk(rd, 32'h0);
    bus(1'b0, ENABLE_B_IDX, 32'h0, rd); chk(rd, 32'h0);
    bus(1'b0, PRIO_A_IDX, 32'h0, rd); chk(rd, 32'h0);
    bus(1'b1, 8'h10, 32'hff, rd);
    bus(1'b0, 8'h10, 32'h0, rd); chk(rd, 32'h0);
    for (int k = 0; k < 40; k++) begin
      // Corners first: all masked with all flags up, then all open
      ea = (k == 0) ? 8'h00 : (k == 1) ? 8'hfd : 8'($random(seed)) & 8'hfd;
      eb = (k == 0) ? 8'h00 : (k == 1) ? 8'hfb : 8'($random(seed)) & 8'hfb;
      pa = (k == 0) ? 8'h00 : (k == 1) ? 8'hfd : 8'($random(seed)) & 8'hfd;
      v = (k < 2) ? 17'h1ffff : 17'($random(seed));
      if (k != 1) begin
        @(posedge clk);
        set_v <= v;
        clr_v <= ~v;
        @(posedge clk);
        set_v <= 17'h0;
        clr_v <= 17'h0;
      end
      bus(1'b1, ENABLE_A_IDX, {24'h0, ea}, rd);
      bus(1'b1, ENABLE_B_IDX, {24'h0, eb}, rd);
      bus(1'b1, PRIO_A_IDX, {24'h0, pa}, rd);
      bus(1'b0, ENABLE_A_IDX, 32'h0, rd); chk(rd, {24'h0, ea});
      bus(1'b0, ENABLE_B_IDX, 32'h0, rd); chk(rd, {24'h0, eb & 8'h3f});
      bus(1'b0, PRIO_A_IDX, 32'h0, rd); chk(rd, {24'h0, pa});
      repeat (4) @(posedge clk);
      @(negedge clk);
      er = exp_req(v, ea, eb);
      eh = er & {4'h0, pa & 8'hfd};
      chk(req, er);
      chk(high, eh);
      chk({any_h, any_l}, {|eh, |(er & ~eh)});
      chk(f, v);
      chk(hresp, HRESP_OKAY);
      // Status views: live source levels and gated requests, low byte only
      raw_e = exp_req(v, 8'hff, 8'hff);
      bus(1'b0, RAW_STAT_IDX, 32'h0, rd); chk(rd, {24'h0, raw_e[7:0]});
      bus(1'b0, REQ_STAT_IDX, 32'h0, rd); chk(rd, {24'h0, er[7:0]});
    end
    end_sim();
  end
endmodule : test_ext_irq_mask_prio
